// *** core/program_counter_stack_indirect.sv ***
// Program counter, return stack control, indirect addressing and bus registers.
`timescale 1ns/10ps

// Overview of operation
// - Thirteen-bit program counter; its low byte is software readable and writable.
// - Upper five counter bits are unreadable; software writes them only through the high latch.
// - Every reset clears the counter's upper bits.
// - Writing the low byte copies latch bits four to zero into the upper part.
// - Call or jump takes bits twelve and eleven from latch bits four and three.
// - Arithmetic into the low byte jumps; no carry reaches the upper bits.
// - Return stack holds eight full thirteen-bit entries.
// - Stack lies outside all address spaces; its pointer is never accessible.
// - Calls and interrupt vectoring push the counter.
// - Return, return with literal and return from interrupt pop the counter.
// - Push and pop leave the high latch unchanged.
// - Stack wraps circularly; the ninth push overwrites the oldest entry.
// - No stack overflow or underflow flag exists.
// - Latch page bits do not affect fetch in this single-page device.
// - Accessing the indirect register accesses the data register the pointer names.
// - With pointer zero, an indirect read returns zero.
// - With pointer zero, an indirect write stores nothing.
// - Indirect address is the bank bit above the eight-bit pointer.
module program_counter_stack_indirect
#(
  parameter int FETCH_BITS = pc_stack_pkg::PROG_ADDR_BITS
)
(
  // Clock and reset.
  input  wire logic                                      clk_sys,
  input  wire logic                                      rst_n,
  // AHB-Lite register slave.
  input  wire logic                                      hsel,
  input  wire logic [31:0]                               haddr,
  input  wire logic [1:0]                                htrans,
  input  wire logic                                      hwrite,
  input  wire logic [2:0]                                hsize,
  input  wire logic [31:0]                               hwdata,
  input  wire logic                                      hready,
  output logic      [31:0]                               hrdata,
  output logic                                           hreadyout,
  output logic                                           hresp,
  // Instruction decoder controls.
  input  wire logic                                      stepEn,
  input  wire logic                                      opCall,
  input  wire logic                                      opGoto,
  input  wire logic                                      opReturn,
  input  wire logic                                      intReq,
  input  wire logic [pc_stack_pkg::JUMP_WIDTH-1:0]       jumpTarget,
  input  wire logic                                      pclWrite,
  input  wire logic [pc_stack_pkg::LOW_WIDTH-1:0]        pclData,
  // Program fetch address.
  output logic      [FETCH_BITS-1:0]                     fetchAddr,
  // Data file request from the decoder.
  input  wire logic                                      fileReq,
  input  wire logic                                      fileWrite,
  input  wire logic [pc_stack_pkg::FILE_WIDTH-1:0]       fileAddr,
  input  wire logic [pc_stack_pkg::FILE_WIDTH-1:0]       fileWdata,
  // Data register file side.
  output logic      [pc_stack_pkg::IND_ADDR_WIDTH-1:0]   dataAddr,
  output logic                                           dataWrite,
  output logic                                           dataRead,
  output logic      [pc_stack_pkg::FILE_WIDTH-1:0]       dataWdata,
  input  wire logic [pc_stack_pkg::FILE_WIDTH-1:0]       dataRdata,
  // Read result back to the decoder.
  output logic      [pc_stack_pkg::FILE_WIDTH-1:0]       readData,
  output logic                                           readValid
);

  // ---------------------------------------------------------------------------
  // Register index decode
  // ---------------------------------------------------------------------------
  // Returns a one-hot hit vector: low byte, latch, pointer, indirect control.
  function automatic logic [3:0] regHit(input logic [31:0] addr);
    regHit = {addr == pc_stack_pkg::OFS_INDIRECT_CTRL,
              addr == pc_stack_pkg::OFS_FILE_POINTER,
              addr == pc_stack_pkg::OFS_PC_HIGH_LATCH,
              addr == pc_stack_pkg::OFS_PC_LOW_BYTE};
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [pc_stack_pkg::PC_WIDTH-1:0]    pc;
  logic [pc_stack_pkg::LATCH_WIDTH-1:0] pcHighLatch;
  logic [pc_stack_pkg::FILE_WIDTH-1:0]  filePointer;
  logic                                 indirectBankBit;
  logic                                 wrPend;
  logic [3:0]                           wrHit;
  logic                                 rdPend;
  logic                                 zeroPend;

  stack_if stk ();

  return_stack #(
    .DEPTH (pc_stack_pkg::STACK_DEPTH),
    .WIDTH (pc_stack_pkg::PC_WIDTH)
  ) u_stack (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .stk     (stk.keeper)
  );

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Only whole-word transfers, single or sequential burst beats, are taken; other sizes are ignored.
  wire       busSel   = hsel & htrans[1] & hready & (hsize == pc_stack_pkg::HSIZE_WORD);
  wire [3:0] addrHit  = regHit(haddr);
  wire       busPclWr = wrPend & wrHit[0];
  wire       busLatWr = wrPend & wrHit[1];
  wire       busFsrWr = wrPend & wrHit[2];
  wire       busIndWr = wrPend & wrHit[3];

  // Upper counter bits never appear on the read mux; only the latch does.
  wire [31:0] readMux =
    addrHit[0] ? {24'h000000, pc[pc_stack_pkg::LOW_WIDTH-1:0]} :
    addrHit[1] ? {27'h0000000, pcHighLatch} :
    addrHit[2] ? {24'h000000, filePointer} :
    addrHit[3] ? {24'h000000, indirectBankBit, 7'h00} :
                 pc_stack_pkg::BUS_ZERO;

  // ---------------------------------------------------------------------------
  // Program flow selection
  // ---------------------------------------------------------------------------
  // Priority: interrupt, call or jump, return, instruction low-byte write,
  // bus low-byte write, then the plain step. The decoder never asserts two
  // flow events together, so the order only settles a misuse.
  wire doInt    = intReq;
  wire doJump   = ~doInt & (opCall | opGoto);
  wire doRet    = ~doInt & ~doJump & opReturn;
  wire flowBusy = doInt | doJump | doRet;
  wire doPclIns = ~flowBusy & pclWrite;
  wire doPclBus = ~flowBusy & ~pclWrite & busPclWr;
  wire doStep   = ~flowBusy & ~pclWrite & ~busPclWr & stepEn;

  // Call and jump take the page bits from the latch, the rest from the opcode.
  wire [pc_stack_pkg::PC_WIDTH-1:0] jumpPc =
    {pcHighLatch[pc_stack_pkg::PAGE_MSB:pc_stack_pkg::PAGE_LSB], jumpTarget};

  // A low-byte write, even an arithmetic result, replaces the byte and loads the
  // upper part from the latch; no carry can ripple upward, so tables crossing a
  // 256-entry block need the latch adjusted by software first.
  wire [pc_stack_pkg::PC_WIDTH-1:0] pclInsPc = {pcHighLatch, pclData};
  wire [pc_stack_pkg::PC_WIDTH-1:0] pclBusPc =
    {pcHighLatch, hwdata[pc_stack_pkg::LOW_WIDTH-1:0]};

  wire [pc_stack_pkg::PC_WIDTH-1:0] next_pc =
    doInt    ? pc_stack_pkg::INT_VECTOR :
    doJump   ? jumpPc :
    doRet    ? stk.topValue :
    doPclIns ? pclInsPc :
    doPclBus ? pclBusPc :
    doStep   ? pc + pc_stack_pkg::PC_ONE :
               pc;

  // Calls and interrupt vectoring push the current counter value.
  assign stk.push      = doInt | (doJump & opCall);
  assign stk.pop       = doRet;
  assign stk.pushValue = pc;

  // ---------------------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------------------
  // Reset clears the whole counter, upper bits included.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pc <= pc_stack_pkg::PC_RESET;
    else
      pc <= next_pc;
  end

  // Fetch only sees the single-page range, so latch page bits have no effect.
  assign fetchAddr = pc[FETCH_BITS-1:0];

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  // The latch changes only on a bus write; stack traffic never touches it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcHighLatch     <= pc_stack_pkg::LATCH_RESET;
      filePointer     <= pc_stack_pkg::FSR_RESET;
      indirectBankBit <= 1'b0;
    end
    else
    begin
      if (busLatWr)
        pcHighLatch <= hwdata[pc_stack_pkg::LATCH_WIDTH-1:0];
      if (busFsrWr)
        filePointer <= hwdata[pc_stack_pkg::FILE_WIDTH-1:0];
      if (busIndWr)
        indirectBankBit <= hwdata[pc_stack_pkg::BANK_BIT_POS];
    end
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------------
  // Zero wait states: read data is registered in the address phase so it stands
  // throughout the data phase; writes are applied at the end of the data phase.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend    <= 1'b0;
      wrHit     <= 4'h0;
      hrdata    <= pc_stack_pkg::BUS_ZERO;
      hreadyout <= 1'b1;
      hresp     <= pc_stack_pkg::HRESP_OKAY;
    end
    else
    begin
      wrPend    <= busSel & hwrite;
      wrHit     <= addrHit;
      hreadyout <= 1'b1;
      hresp     <= pc_stack_pkg::HRESP_OKAY;
      if (busSel && !hwrite)
        hrdata <= readMux;
    end
  end

  // ---------------------------------------------------------------------------
  // Indirect addressing
  // ---------------------------------------------------------------------------
  // The indirect register is not storage: its address redirects through the
  // pointer, with the bank bit on top; direct accesses pass through.
  wire isIndf  = fileAddr == pc_stack_pkg::INDIRECT_ACCESS_REG_ADDR;
  wire fsrZero = filePointer == pc_stack_pkg::FSR_ZERO;
  wire selfRef = isIndf & fsrZero;
  wire [pc_stack_pkg::IND_ADDR_WIDTH-1:0] effAddr =
    isIndf ? {indirectBankBit, filePointer} : {1'b0, fileAddr};

  // A self-referencing access is suppressed toward the file: reads return zero
  // and writes store nothing. Status flags are the decoder's business.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataAddr  <= '0;
      dataWrite <= 1'b0;
      dataRead  <= 1'b0;
      dataWdata <= pc_stack_pkg::DATA_ZERO;
      rdPend    <= 1'b0;
      zeroPend  <= 1'b0;
    end
    else
    begin
      dataAddr  <= effAddr;
      dataWrite <= fileReq & fileWrite & ~selfRef;
      dataRead  <= fileReq & ~fileWrite & ~selfRef;
      dataWdata <= fileWdata;
      rdPend    <= fileReq & ~fileWrite;
      zeroPend  <= fileReq & ~fileWrite & selfRef;
    end
  end

  // Read data is taken from the file one cycle after the address goes out.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData  <= pc_stack_pkg::DATA_ZERO;
      readValid <= 1'b0;
    end
    else
    begin
      readValid <= rdPend;
      readData  <= zeroPend ? pc_stack_pkg::DATA_ZERO : dataRdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cbDefault @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_PCL_LOADS_LATCH: assert property (
    doPclIns |=> pc == {$past(pcHighLatch), $past(pclData)})
    else $error("Low byte write did not load the latch into the upper part.");

  AST_JUMP_PAGE: assert property (
    doJump |=> (pc[pc_stack_pkg::PC_WIDTH-1:pc_stack_pkg::JUMP_WIDTH] ==
                $past(pcHighLatch[pc_stack_pkg::PAGE_MSB:pc_stack_pkg::PAGE_LSB])) &&
               (pc[pc_stack_pkg::JUMP_WIDTH-1:0] == $past(jumpTarget)))
    else $error("Call or jump did not take page bits from the latch.");

  AST_STEP_ONE: assert property (
    doStep |=> pc == $past(pc) + pc_stack_pkg::PC_ONE)
    else $error("Counter did not advance by one on a plain fetch.");

  AST_LATCH_KEPT: assert property (
    (stk.push || stk.pop) && !busLatWr |=> $stable(pcHighLatch))
    else $error("Stack traffic changed the high latch.");

  AST_CALL_RETURN: assert property (
    (doJump && opCall) ##1 (doRet && !stk.push) |=> pc == $past(pc, 2))
    else $error("Return right after a call did not restore the pushed address.");

  AST_INT_PUSH: assert property (
    doInt |-> stk.push && stk.pushValue == pc ##1 pc == pc_stack_pkg::INT_VECTOR)
    else $error("Interrupt did not push the counter and take the vector.");

  AST_SELF_READ_ZERO: assert property (
    fileReq && !fileWrite && selfRef |=> !dataRead ##1 readValid && readData == 8'h00)
    else $error("Indirect read with a zero pointer did not return zero.");

  AST_SELF_WRITE_NOP: assert property (
    fileReq && fileWrite && selfRef |=> !dataWrite)
    else $error("Indirect write with a zero pointer reached the file.");

  AST_INDIRECT_ADDR: assert property (
    fileReq && isIndf && !fsrZero |=> dataAddr == {$past(indirectBankBit), $past(filePointer)})
    else $error("Indirect address was not formed from bank bit and pointer.");

  AST_BUS_NO_HIGH: assert property (
    busSel && !hwrite && addrHit[0] |=> hrdata[31:8] == 24'h000000)
    else $error("Upper counter bits leaked onto a low byte read.");

  // A bus write to the low byte must load the latch into the upper part as well.
  AST_BUS_PCL_WRITE: assert property (
    doPclBus |=> pc == {$past(pcHighLatch), $past(hwdata[pc_stack_pkg::LOW_WIDTH-1:0])})
    else $error("Bus low byte write did not load the counter.");

  // Accesses that do not name the indirect register must reach the file unchanged.
  AST_DIRECT_ADDR: assert property (
    fileReq && !isIndf |=> dataAddr == {1'b0, $past(fileAddr)})
    else $error("Direct access did not pass its address through.");

  AST_WRITE_REACHES: assert property (
    fileReq && fileWrite && !selfRef |=> dataWrite && dataWdata == $past(fileWdata))
    else $error("Write did not reach the data file.");

  COV_CALL: cover property (doJump && opCall);
  COV_RETURN: cover property (doRet);
  COV_SELF_READ: cover property (fileReq && !fileWrite && selfRef);
  COV_COMPUTED_JUMP: cover property (doPclIns);

endmodule // program_counter_stack_indirect

// *** core/pc_stack_pkg.sv ***
// Shared constants for the program counter, return stack and indirect addressing unit.
package pc_stack_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int PC_WIDTH       = 13;
  localparam int LOW_WIDTH      = 8;
  localparam int LATCH_WIDTH    = 5;
  localparam int JUMP_WIDTH     = 11;
  localparam int STACK_DEPTH    = 8;
  localparam int FILE_WIDTH     = 8;
  localparam int IND_ADDR_WIDTH = 9;
  localparam int PROG_ADDR_BITS = 11;
  localparam int BUS_WIDTH      = 32;

  // ---------------------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ---------------------------------------------------------------------------
  localparam logic [31:0] OFS_PC_LOW_BYTE   = 32'h0000_0000;
  localparam logic [31:0] OFS_PC_HIGH_LATCH = 32'h0000_0004;
  localparam logic [31:0] OFS_FILE_POINTER  = 32'h0000_0008;
  localparam logic [31:0] OFS_INDIRECT_CTRL = 32'h0000_000C;

  // Position of the indirect bank bit inside the indirect control register.
  localparam int BANK_BIT_POS = 7;
  // Page select bits inside the latch.
  localparam int PAGE_MSB = 4;
  localparam int PAGE_LSB = 3;

  // ---------------------------------------------------------------------------
  // Reset values and fixed codes
  // ---------------------------------------------------------------------------
  localparam logic [PC_WIDTH-1:0]    PC_RESET      = 13'h0000;
  localparam logic [PC_WIDTH-1:0]    PC_ONE        = 13'h0001;
  localparam logic [PC_WIDTH-1:0]    INT_VECTOR    = 13'h0004;
  localparam logic [LATCH_WIDTH-1:0] LATCH_RESET   = 5'h00;
  localparam logic [FILE_WIDTH-1:0]  FSR_RESET     = 8'h00;
  localparam logic [FILE_WIDTH-1:0]  FSR_ZERO      = 8'h00;
  localparam logic [FILE_WIDTH-1:0]  INDIRECT_ACCESS_REG_ADDR     = 8'h00;
  localparam logic [FILE_WIDTH-1:0]  DATA_ZERO     = 8'h00;
  localparam logic [BUS_WIDTH-1:0]   BUS_ZERO      = 32'h0000_0000;
  localparam logic [2:0]             HSIZE_WORD    = 3'h2;
  localparam logic                   HRESP_OKAY    = 1'b0;

endpackage

// *** core/stack_if.sv ***
// Push, pop and data lines between the flow unit and its return stack.
`timescale 1ns/10ps
interface stack_if;
  logic                             push;
  logic                             pop;
  logic [pc_stack_pkg::PC_WIDTH-1:0] pushValue;
  logic [pc_stack_pkg::PC_WIDTH-1:0] topValue;

  modport owner  (output push, output pop, output pushValue, input topValue);
  modport keeper (input push, input pop, input pushValue, output topValue);
endinterface

// *** core/return_stack.sv ***
// Circular hardware return stack with a hidden pointer.
`timescale 1ns/10ps
module return_stack
#(
  parameter int DEPTH = pc_stack_pkg::STACK_DEPTH,
  parameter int WIDTH = pc_stack_pkg::PC_WIDTH
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Stack traffic.
  stack_if.keeper  stk
);

  localparam int PTR_W = $clog2(DEPTH);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // The pointer never leaves this module, so no instruction can see it.
  // No overflow or underflow flag exists; wrapping is silent.
  logic [WIDTH-1:0] entry [DEPTH];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] topIdx;

  // The top entry sits one below the pointer.
  assign topIdx       = ptr - 1'b1;
  assign stk.topValue = entry[topIdx];

  // Pointer moves and wraps modulo the depth, so a ninth push overwrites the first.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptr <= '0;
    else if (stk.push)
      ptr <= ptr + 1'b1;
    else if (stk.pop)
      ptr <= ptr - 1'b1;
  end

  // Entries hold a full program counter each; they need no reset.
  always_ff @(posedge clk_sys)
  begin
    if (stk.push)
      entry[ptr] <= stk.pushValue;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_STACK_WRAP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (stk.push && ptr == PTR_W'(DEPTH - 1)) |=> (ptr == '0))
    else $error("Stack pointer did not wrap after the last entry.");

  COV_STACK_WRAP: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    stk.push && ptr == PTR_W'(DEPTH - 1));

endmodule // return_stack

// *** verif/data_file_model.sv ***
// Behavioural data register file on the far side of the indirect addressing path.
`timescale 1ns/10ps
module data_file_model
(
  // Clock.
  input wire logic       clk_sys,
  // Access from the unit.
  input wire logic [8:0] dataAddr,
  input wire logic       dataWrite,
  input wire logic       dataRead,
  input wire logic [7:0] dataWdata,
  output logic     [7:0] dataRdata
);
  logic [7:0] mem [512];
  logic [7:0] junk = 8'h3C;

  // A known fill lets the bench predict any cell that was never written.
  initial for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;

  // Data only stands while a read is asked for; otherwise it toggles, so a late sample shows.
  assign dataRdata = dataRead ? mem[dataAddr] : junk;

  // Writes land at the full nine-bit resolved address.
  always @(posedge clk_sys)
  begin
    junk <= ~junk;
    if (dataWrite) mem[dataAddr] <= dataWdata;
  end
endmodule // data_file_model

// *** verif/program_counter_stack_indirect_tb_top.sv ***
// Self-checking bench for the program counter, return stack and indirect addressing unit.
`timescale 1ns/10ps
module program_counter_stack_indirect_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n, hsel, hwrite, hreadyout, hresp;
  logic        stepEn, opCall, opGoto, opReturn, intReq, pclWrite;
  logic        fileReq, fileWrite, dataWrite, dataRead, readValid;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] jumpTarget, fetchAddr;
  logic [7:0]  pclData, fileAddr, fileWdata, dataWdata, dataRdata, readData, p;
  logic [8:0]  dataAddr;
  // Reference model state.
  logic [12:0] pc, stk [8];
  logic [7:0]  mem [512];
  logic [4:0]  latch;
  logic [7:0]  ptr;
  logic        bank;
  int          sp, seed, mismatches, numChecks, nWrites, nModel;

  program_counter_stack_indirect uut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stepEn, .opCall,
    .opGoto, .opReturn, .intReq, .jumpTarget, .pclWrite, .pclData, .fetchAddr, .fileReq,
    .fileWrite, .fileAddr, .fileWdata, .dataAddr, .dataWrite, .dataRead, .dataWdata,
    .dataRdata, .readData, .readValid);
  data_file_model far (.clk_sys, .dataAddr, .dataWrite, .dataRead, .dataWdata, .dataRdata);

  always #5 clk_sys = ~clk_sys;
  // Every write pulse is counted, so a stray self-referencing store cannot hide.
  always @(posedge clk_sys) if (dataWrite === 1'b1) nWrites++;

  // ----------------------------------------------------------------
  // Compare, bus and stimulus tasks
  // ----------------------------------------------------------------
  task closeOut();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task checkVal(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task checkPc();
    checkVal("fetchAddr", {21'h0, pc[10:0]}, {21'h0, fetchAddr});
  endtask

  task stuck();
    mismatches++;
    $display("mismatch wait expected done seen stuck");
    closeOut();
  endtask

  // Waits for an edge with hready high; the bound only guards against a hang.
  task waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) stuck();
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= pc_stack_pkg::HSIZE_WORD;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    waitReady();
    r = hrdata;
  endtask

  // Kinds: 0 step, 1 call, 2 jump, 3 return, 4 interrupt, 5 low byte write.
  task flow(input int k, input logic [10:0] t, input logic [7:0] d);
    @(posedge clk_sys);
    stepEn <= (k == 0);
    opCall <= (k == 1);
    opGoto <= (k == 2);
    opReturn <= (k == 3);
    intReq <= (k == 4);
    pclWrite <= (k == 5);
    jumpTarget <= t;
    pclData <= d;
    @(posedge clk_sys);
    {stepEn, opCall, opGoto, opReturn, intReq, pclWrite} <= 6'h00;
    if (k == 1 || k == 4)
    begin
      stk[sp] = pc;
      sp = (sp + 1) % 8;
    end
    if (k == 3)
    begin
      sp = (sp + 7) % 8;
      pc = stk[sp];
    end
    else if (k == 0) pc = pc + 13'h0001;
    else if (k == 4) pc = pc_stack_pkg::INT_VECTOR;
    else if (k == 5) pc = {latch, d};
    else pc = {latch[4:3], t};
    #1 checkPc();
  endtask

  task fileAcc(input logic w, input logic [7:0] a, input logic [7:0] wd);
    logic [8:0] ea;
    logic       selfRef;
    int n;
    ea = (a == 8'h00) ? {bank, ptr} : {1'b0, a};
    // Only a zero pointer makes the indirect register refer to itself.
    selfRef = (a == 8'h00) && (ptr == 8'h00);
    @(posedge clk_sys);
    fileReq <= 1'b1;
    fileWrite <= w;
    fileAddr <= a;
    fileWdata <= wd;
    @(posedge clk_sys);
    fileReq <= 1'b0;
    if (w)
    begin
      if (!selfRef) mem[ea] = wd;
      if (!selfRef) nModel++;
      repeat (2) @(posedge clk_sys);
    end
    else
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys);
        #1 n++;
      end
      while (readValid !== 1'b1 && n < 4);
      if (readValid !== 1'b1) stuck();
      checkVal("readData", selfRef ? 32'h0 : {24'h0, mem[ea]}, {24'h0, readData});
    end
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    {stepEn, opCall, opGoto, opReturn, intReq, pclWrite, jumpTarget, pclData} = '0;
    {fileReq, fileWrite, fileAddr, fileWdata} = '0;
    {latch, ptr, bank, pc, sp, mismatches, numChecks, nWrites, nModel} = '0;
    seed = 65;
    rst_n = 1'b0;
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 checkPc();
    bus(1'b0, pc_stack_pkg::OFS_PC_HIGH_LATCH, 32'h0);
    checkVal("latch", 32'h0, r);
    done("reset");
    bus(1'b1, pc_stack_pkg::OFS_PC_HIGH_LATCH, 32'h1F);
    latch = 5'h1F;
    bus(1'b1, pc_stack_pkg::OFS_PC_LOW_BYTE, 32'hFF);
    pc = 13'h1FFF;
    #1 checkPc();
    bus(1'b0, pc_stack_pkg::OFS_PC_LOW_BYTE, 32'h0);
    checkVal("pcLow", 32'hFF, r);
    checkVal("hresp", 32'h0, {31'h0, hresp});
    flow(0, 11'h0, 8'h0);
    done("low byte and step");
    for (int i = 0; i < 10; i++) flow(1, 11'($random(seed)), 8'h0);
    for (int i = 0; i < 8; i++) flow(3, 11'h0, 8'h0);
    // A return in the cycle right after a call must restore the counter at the call.
    @(posedge clk_sys);
    opCall <= 1'b1;
    jumpTarget <= 11'($random(seed));
    @(posedge clk_sys);
    opCall <= 1'b0;
    opReturn <= 1'b1;
    @(posedge clk_sys);
    opReturn <= 1'b0;
    stk[sp] = pc;
    #1 checkPc();
    bus(1'b0, pc_stack_pkg::OFS_PC_HIGH_LATCH, 32'h0);
    checkVal("latch", 32'h1F, r);
    flow(2, 11'($random(seed)), 8'h0);
    flow(4, 11'h0, 8'h0);
    flow(3, 11'h0, 8'h0);
    flow(5, 11'h0, 8'($random(seed)));
    bus(1'b0, 32'h10, 32'h0);
    checkVal("unmapped", 32'h0, r);
    done("stack and jumps");
    p = 8'($random(seed)) | 8'h01;
    bus(1'b1, pc_stack_pkg::OFS_FILE_POINTER, {24'h0, p});
    ptr = p;
    fileAcc(1'b1, 8'h00, p ^ 8'h5A);
    fileAcc(1'b0, 8'h00, 8'h0);
    bus(1'b1, pc_stack_pkg::OFS_INDIRECT_CTRL, 32'h80);
    bank = 1'b1;
    fileAcc(1'b0, 8'h00, 8'h0);
    bus(1'b0, pc_stack_pkg::OFS_INDIRECT_CTRL, 32'h0);
    checkVal("bankBit", 32'h80, r);
    bus(1'b1, pc_stack_pkg::OFS_INDIRECT_CTRL, 32'h0);
    bus(1'b1, pc_stack_pkg::OFS_FILE_POINTER, 32'h0);
    {bank, ptr} = '0;
    fileAcc(1'b1, 8'h00, 8'h77);
    fileAcc(1'b0, 8'h00, 8'h0);
    fileAcc(1'b0, p, 8'h0);
    checkVal("dataWrites", 32'(nModel), 32'(nWrites));
    done("indirect");
    // A reset in mid-run must clear the counter again while its upper bits are set.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    {latch, pc, sp} = '0;
    #1 checkPc();
    bus(1'b0, pc_stack_pkg::OFS_PC_HIGH_LATCH, 32'h0);
    checkVal("latch", 32'h0, r);
    done("second reset");
    closeOut();
  end
endmodule // program_counter_stack_indirect_tb_top
